// ===== srei_rx_ctrl.sv
// Serial receive control, receive error detection and interrupt factors
`timescale 1ns/1ns
// Overview of operation
// [RQ1] Receive enable set puts receiver in standby, ready to shift data in
// [RQ2] In synchronous modes receive enable also enables the clock pin; the code enables it in master mode only, not in slave
// [RQ3] In synchronous modes a trigger write starts one word
// [RQ4] Synchronous slave drives ready output low on trigger write
// [RQ5] Async: trigger write marks buffer empty, else next word overruns
// [RQ6] Trigger bit reads 1 while receiving, 0 in standby or stopped
// [RQ7] Software clears receive enable before changing transfer settings
// [RQ8] Async with parity enabled checks odd or even parity at transfer
// [RQ9] Parity mismatch sets parity error and receive error factor
// [RQ10] Stop bit of 0 sets framing error and receive error factor
// [RQ11] After any error word still goes to buffer, receiving continues
// [RQ12] Async word completing before trigger write is an overrun
// [RQ13] Slave word completing before previous word read is an overrun
// [RQ14] Overrun sets overrun error and receive error factor
// [RQ15] Async transfer in same cycle as trigger write counts as overrun
// [RQ16] Error flags and factor flags clear only by writing 1
// [RQ17] Three factor flags, three enables and a two-bit priority
// [RQ18] Transmit done sets its flag; request gated by enable, priority
// [RQ19] Word into buffer sets receive done flag, gated request
// [RQ20] Receive error flag set with receive completion, gated request
// [RQ21] Overrun gives no receive done; error request outranks it
// [RQ22] Error handler also clears receive done after parity or framing
module srei_rx_ctrl #(
   parameter int ADDR_W = 18
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [ADDR_W-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic timer_tick_i,
   input wire logic sin_i,
   input wire logic sclk_i,
   input wire logic tx_done_i,
   input wire logic cpu_irq_level_low_i,
   input wire logic cpu_irq_level_high_i,
   output logic sclk_o,
   output logic sclk_oe_o,
   output logic slave_ready_out_o,
   output logic irq_err_req_o,
   output logic irq_rx_req_o,
   output logic irq_tx_req_o,
   output logic [23:0] irq_vec_o
);

   // ----------------------------------------------------------------
   // Elaboration check
   // ----------------------------------------------------------------
   if (ADDR_W < srei_pkg::ADDR_W_MIN) begin : g_addr_chk
      $error("ADDR_W too small for the register indices");
   end

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic sin_s1;
      logic sin_s2;
      logic sck_s1;
      logic sck_s2;
      logic sck_prev;
      srei_pkg::srei_rx_state_t state;
      logic [3:0] cnt;
      logic [3:0] bitn;
      logic stopn;
      logic fbad;
      logic pbit;
      logic [7:0] shift;
      logic [7:0] rxbuf;
      logic buf_full;
      logic buf_unread;
      logic rx_en;
      logic [1:0] mode;
      logic par_en;
      logic par_odd;
      logic eight;
      logic two_stop;
      logic parity_error_flag;
      logic framing_error_flag;
      logic overrun_error_flag;
      logic [2:0] fac;
      logic [2:0] ena;
      logic [1:0] prio;
      logic sclk;
      logic sclk_oe;
      logic slave_ready_out;
      logic pready;
      logic pslverr;
      logic [7:0] prdata;
      logic irq_err;
      logic irq_rx;
      logic irq_tx;
      logic [23:0] vec;
   } srei_state_t;

   srei_state_t r;
   srei_state_t n;
   logic [15:0] idx;
   logic is_prio, is_ena, is_fac, is_ctrl, is_stat, is_data;
   logic wr, rd, trg_wr, data_rd;
   logic is_async, is_master, is_slave;
   logic sin, sck_rise, sample, done, fer_hit;
   logic par_err, fer_err, ovr, busy;
   logic [3:0] last_bit;
   logic [7:0] word;
   logic [7:0] rdmux;
   logic [2:0] st_clr, fac_clr;
   logic [1:0] lvl;

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   // APB decode, receiver sequencing, flags and interrupt requests
   always_comb begin
      n = r;
      // Bus decode; upper address bits must be zero to hit a register
      idx = paddr_i[17:2];
      is_prio = ((paddr_i >> 18) == '0) && (idx == srei_pkg::IDX_PRIO);
      is_ena = ((paddr_i >> 18) == '0) && (idx == srei_pkg::IDX_ENA);
      is_fac = ((paddr_i >> 18) == '0) && (idx == srei_pkg::IDX_FAC);
      is_ctrl = ((paddr_i >> 18) == '0) && (idx == srei_pkg::IDX_CTRL);
      is_stat = ((paddr_i >> 18) == '0) && (idx == srei_pkg::IDX_STAT);
      is_data = ((paddr_i >> 18) == '0) && (idx == srei_pkg::IDX_DATA);
      wr = psel_i && penable_i && r.pready && pwrite_i;
      rd = psel_i && penable_i && r.pready && !pwrite_i;
      trg_wr = wr && is_ctrl && pwdata_i[srei_pkg::CB_TRG] && r.rx_en;
      data_rd = rd && is_data;
      is_master = (r.mode == srei_pkg::MODE_MASTER);
      is_slave = (r.mode == srei_pkg::MODE_SLAVE);
      is_async = !is_master && !is_slave;
      busy = (r.state != srei_pkg::RX_OFF) &&
             (r.state != srei_pkg::RX_STANDBY);
      lvl = {cpu_irq_level_high_i, cpu_irq_level_low_i};

      // Pin synchronisers; data uses the second stage, clock edges compare it with a third
      n.sin_s1 = sin_i;
      n.sin_s2 = r.sin_s1;
      n.sck_s1 = sclk_i;
      n.sck_s2 = r.sck_s1;
      n.sck_prev = r.sck_s2;
      sin = r.sin_s2;
      sck_rise = r.sck_s2 && !r.sck_prev;

      // Read mux, latched in the setup cycle so data is a flop output
      rdmux = 8'h00;
      if (is_prio) rdmux[srei_pkg::PRIO_LSB +: 2] = r.prio;
      if (is_ena) rdmux[2:0] = r.ena;
      if (is_fac) rdmux[2:0] = r.fac;
      if (is_ctrl) begin
         rdmux = {r.two_stop, r.eight, r.par_odd, r.par_en, r.mode,
                  busy, r.rx_en}; // [RQ6]
      end
      if (is_stat) rdmux[2:0] = {r.overrun_error_flag, r.framing_error_flag, r.parity_error_flag};
      if (is_data) rdmux = r.rxbuf;
      n.pready = psel_i && !penable_i;
      n.pslverr = psel_i && !penable_i &&
                  !(is_prio || is_ena || is_fac || is_ctrl || is_stat ||
                    is_data);
      if (psel_i && !penable_i) n.prdata = rdmux;

      // Bit timing: 16 timer ticks per bit, or the slave's clock edges
      if (timer_tick_i && busy) n.cnt = r.cnt + 4'h1;
      if (is_slave) begin
         sample = sck_rise;
      end else if (is_master) begin
         sample = timer_tick_i && (r.cnt == srei_pkg::OVS_LAST);
      end else begin
         sample = timer_tick_i && (r.cnt == srei_pkg::SAMPLE_PT);
      end
      // Master clock: falls mid-bit, rises at the sampling point
      if (is_master && r.state == srei_pkg::RX_DATA && timer_tick_i) begin
         if (r.cnt == srei_pkg::MCLK_FALL) n.sclk = 1'h0;
         if (r.cnt == srei_pkg::OVS_LAST) n.sclk = 1'h1;
      end
      // Ready returns high at the first rising clock of the word
      if (is_slave && sck_rise && !r.slave_ready_out) n.slave_ready_out = 1'h1;
      last_bit = (is_async && !r.eight) ? srei_pkg::BITS7_LAST :
                 srei_pkg::BITS8_LAST;

      // Receiver sequence
      done = 1'h0;
      fer_hit = 1'h0;
      case (r.state)
         srei_pkg::RX_OFF: begin
            n.state = srei_pkg::RX_OFF;
         end
         srei_pkg::RX_STANDBY: begin
            if (is_async) begin
               // A low line at a tick is taken as a start bit
               if (timer_tick_i && !sin) begin
                  n.state = srei_pkg::RX_START;
                  n.cnt = 4'h0;
               end
            end else if (trg_wr) begin
               n.state = srei_pkg::RX_DATA; // [RQ3]
               n.cnt = 4'h0;
               n.bitn = 4'h0;
               n.sclk = 1'h1;
               if (is_slave) n.slave_ready_out = 1'h0; // [RQ4]
            end
         end
         srei_pkg::RX_START: begin
            // Start bit gone high at its centre: noise, back to standby
            if (sample) begin
               n.state = sin ? srei_pkg::RX_STANDBY : srei_pkg::RX_DATA;
               n.bitn = 4'h0;
            end
         end
         srei_pkg::RX_DATA: begin
            if (sample) begin
               n.shift = {sin, r.shift[7:1]}; // [RQ1]
               n.bitn = r.bitn + 4'h1;
               if (r.bitn == last_bit) begin
                  if (!is_async) begin
                     done = 1'h1;
                     n.state = srei_pkg::RX_STANDBY;
                  end else begin
                     n.state = r.par_en ? srei_pkg::RX_PARITY :
                               srei_pkg::RX_STOP;
                     n.stopn = 1'h0;
                     n.fbad = 1'h0;
                  end
               end
            end
         end
         srei_pkg::RX_PARITY: begin
            if (sample) begin
               n.pbit = sin;
               n.state = srei_pkg::RX_STOP;
            end
         end
         srei_pkg::RX_STOP: begin
            if (sample) begin
               if (r.two_stop && !r.stopn) begin
                  n.stopn = 1'h1;
                  n.fbad = r.fbad || !sin;
               end else begin
                  done = 1'h1;
                  fer_hit = r.fbad || !sin; // [RQ10]
                  n.state = srei_pkg::RX_STANDBY;
               end
            end
         end
         default: begin
            n.state = srei_pkg::RX_OFF;
         end
      endcase
      // Enable gates the whole receiver; clearing it stops a word
      if (!r.rx_en) begin
         n.state = srei_pkg::RX_OFF;
         n.sclk = 1'h1;
      end else if (r.state == srei_pkg::RX_OFF) begin
         n.state = srei_pkg::RX_STANDBY; // [RQ1]
      end

      // Completed word and its errors
      if (!is_async) begin
         word = {sin, r.shift[7:1]};
      end else if (r.eight) begin
         word = r.shift;
      end else begin
         word = {1'h0, r.shift[7:1]};
      end
      par_err = done && is_async && r.par_en &&
                ((^word ^ r.pbit) != r.par_odd); // [RQ8]
      fer_err = done && is_async && fer_hit;
      if (is_async) begin
         ovr = done && (r.buf_full || trg_wr); // [RQ12] [RQ15]
      end else begin
         ovr = done && is_slave && r.buf_unread; // [RQ13]
      end
      // Word always reaches the buffer, even when flagged bad
      if (done) n.rxbuf = word; // [RQ11]
      n.buf_full = (r.buf_full && !(trg_wr && is_async)) || done; // [RQ5]
      n.buf_unread = (r.buf_unread && !data_rd) || done;

      // Write-one-to-clear flags; a set in the same cycle wins
      st_clr = (wr && is_stat) ? pwdata_i[2:0] : 3'h0;
      fac_clr = (wr && is_fac) ? pwdata_i[2:0] : 3'h0;
      n.parity_error_flag = (r.parity_error_flag && !st_clr[srei_pkg::SB_PER]) || par_err; // [RQ9]
      n.framing_error_flag = (r.framing_error_flag && !st_clr[srei_pkg::SB_FER]) || fer_err; // [RQ10]
      n.overrun_error_flag = (r.overrun_error_flag && !st_clr[srei_pkg::SB_OER]) || ovr; // [RQ14]
      n.fac = r.fac & ~fac_clr; // [RQ16]
      if (par_err || fer_err || ovr) n.fac[srei_pkg::FB_ERR] = 1'h1; // [RQ20]
      if (done && !ovr) n.fac[srei_pkg::FB_RX] = 1'h1; // [RQ19] [RQ21]
      if (tx_done_i) n.fac[srei_pkg::FB_TX] = 1'h1; // [RQ18]

      // Register writes
      if (wr && is_ena) n.ena = pwdata_i[2:0]; // [RQ17]
      if (wr && is_prio) n.prio = pwdata_i[srei_pkg::PRIO_LSB +: 2];
      if (wr && is_ctrl) begin
         n.rx_en = pwdata_i[srei_pkg::CB_EN];
         n.mode = pwdata_i[srei_pkg::CB_MODE +: 2];
         n.par_en = pwdata_i[srei_pkg::CB_PEN];
         n.par_odd = pwdata_i[srei_pkg::CB_PODD];
         n.eight = pwdata_i[srei_pkg::CB_EIGHT];
         n.two_stop = pwdata_i[srei_pkg::CB_TWOSTOP];
      end
      // Clock pin driven only by an enabled master
      n.sclk_oe = n.rx_en && (n.mode == srei_pkg::MODE_MASTER); // [RQ2]

      // Requests: enable and priority above the CPU level; error first
      n.irq_err = r.fac[srei_pkg::FB_ERR] && r.ena[srei_pkg::FB_ERR] &&
                  (r.prio > lvl); // [RQ20]
      n.irq_rx = r.fac[srei_pkg::FB_RX] && r.ena[srei_pkg::FB_RX] &&
                 (r.prio > lvl) && !n.irq_err; // [RQ19] [RQ21]
      n.irq_tx = r.fac[srei_pkg::FB_TX] && r.ena[srei_pkg::FB_TX] &&
                 (r.prio > lvl); // [RQ18]
      if (n.irq_err) begin
         n.vec = srei_pkg::VEC_ERR;
      end else if (n.irq_rx) begin
         n.vec = srei_pkg::VEC_RX;
      end else if (n.irq_tx) begin
         n.vec = srei_pkg::VEC_TX;
      end else begin
         n.vec = srei_pkg::VEC_NONE;
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   // Clock enable low freezes everything, bus handshake included
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         r <= '0;
         r.state <= srei_pkg::RX_OFF;
         r.sclk <= 1'h1;
         r.slave_ready_out <= 1'h1;
      end else if (ce_i) begin
         r <= n;
      end
   end

   // Outputs straight from the state register
   assign prdata_o = {24'h000000, r.prdata};
   assign pready_o = r.pready;
   assign pslverr_o = r.pslverr;
   assign sclk_o = r.sclk;
   assign sclk_oe_o = r.sclk_oe;
   assign slave_ready_out_o = r.slave_ready_out;
   assign irq_err_req_o = r.irq_err;
   assign irq_rx_req_o = r.irq_rx;
   assign irq_tx_req_o = r.irq_tx;
   assign irq_vec_o = r.vec;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   AST_SLAVE_READY_LOW: assert property ( // [RQ4]
      @(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && trg_wr && is_slave && r.state == srei_pkg::RX_STANDBY)
      |=> !slave_ready_out_o)
      else $error("slave ready did not fall on trigger write");

   AST_SYNC_TRIGGER_STARTS: assert property ( // [RQ3]
      @(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && trg_wr && !is_async && r.state == srei_pkg::RX_STANDBY)
      |=> (r.state == srei_pkg::RX_DATA && r.bitn == 4'h0))
      else $error("trigger write did not start a synchronous word");

   AST_PARITY_SETS: assert property ( // [RQ9]
      @(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && par_err) |=> (r.parity_error_flag && r.fac[srei_pkg::FB_ERR]))
      else $error("parity error not flagged");

   AST_FRAMING_SETS: assert property ( // [RQ10]
      @(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && fer_err) |=> (r.framing_error_flag && r.fac[srei_pkg::FB_ERR]))
      else $error("framing error not flagged");

   AST_OVERRUN_SETS: assert property ( // [RQ14]
      @(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && ovr) |=> (r.overrun_error_flag && r.fac[srei_pkg::FB_ERR] && r.buf_full))
      else $error("overrun not flagged");

   AST_SAME_CYCLE_OVR: assert property ( // [RQ15]
      @(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && done && is_async && trg_wr) |=> r.overrun_error_flag)
      else $error("transfer during trigger write not an overrun");

   AST_OVR_NO_RXDONE: assert property ( // [RQ21]
      @(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && ovr && !r.fac[srei_pkg::FB_RX]) |=> !r.fac[srei_pkg::FB_RX])
      else $error("overrun raised receive done");

   AST_RXDONE_BUFFER: assert property ( // [RQ19]
      @(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && done && !ovr)
      |=> (r.fac[srei_pkg::FB_RX] && r.rxbuf == $past(word)))
      else $error("receive done or buffer not updated");

   AST_FLAG_STICKY: assert property ( // [RQ16]
      @(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && r.overrun_error_flag && !(wr && is_stat && pwdata_i[srei_pkg::SB_OER]))
      |=> r.overrun_error_flag)
      else $error("overrun flag cleared without a write of one");

   AST_TX_IRQ_GATE: assert property ( // [RQ18]
      @(posedge clk_i) disable iff (!rst_n_i)
      ce_i |=> (irq_tx_req_o == $past(r.fac[srei_pkg::FB_TX] &&
         r.ena[srei_pkg::FB_TX] && (r.prio > lvl))))
      else $error("transmit request not gated by enable and priority");

endmodule : srei_rx_ctrl

// ===== srei_pkg.sv
// Shared constants and types of the serial receive, error and interrupt block
package srei_pkg;

   // ----------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam int ADDR_W_MIN = 18;
   localparam logic [15:0] IDX_PRIO = 16'hFF21;
   localparam logic [15:0] IDX_ENA = 16'hFF24;
   localparam logic [15:0] IDX_FAC = 16'hFF28;
   localparam logic [15:0] IDX_CTRL = 16'hFF30;
   localparam logic [15:0] IDX_STAT = 16'hFF31;
   localparam logic [15:0] IDX_DATA = 16'hFF32;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CB_EN = 0;       // Receive enable bit
   localparam int CB_TRG = 1;      // Receive trigger bit
   localparam int CB_MODE = 2;     // Two-bit transfer mode
   localparam int CB_PEN = 4;      // Parity enable bit
   localparam int CB_PODD = 5;     // Parity select bit, 1 = odd
   localparam int CB_EIGHT = 6;    // 1 = eight data bits in async mode
   localparam int CB_TWOSTOP = 7;  // 1 = two stop bits
   localparam int SB_PER = 0;
   localparam int SB_FER = 1;
   localparam int SB_OER = 2;
   localparam int FB_ERR = 0;      // Receive error factor / enable
   localparam int FB_RX = 1;       // Receive done factor / enable
   localparam int FB_TX = 2;       // Transmit done factor / enable
   localparam int PRIO_LSB = 4;

   // ----------------------------------------------------------------
   // Modes, timing and vectors
   // ----------------------------------------------------------------
   localparam logic [1:0] MODE_ASYNC = 2'h0;
   localparam logic [1:0] MODE_MASTER = 2'h1;
   localparam logic [1:0] MODE_SLAVE = 2'h2;
   localparam logic [3:0] OVS_LAST = 4'hF;    // Last of 16 timer ticks
   localparam logic [3:0] SAMPLE_PT = 4'h7;   // Eighth tick: bit centre
   localparam logic [3:0] MCLK_FALL = 4'h7;   // Master clock falls here
   localparam logic [3:0] BITS8_LAST = 4'h7;
   localparam logic [3:0] BITS7_LAST = 4'h6;
   localparam logic [23:0] VEC_ERR = 24'h00001A;
   localparam logic [23:0] VEC_RX = 24'h00001C;
   localparam logic [23:0] VEC_TX = 24'h00001E;
   localparam logic [23:0] VEC_NONE = 24'h000000;

   typedef enum logic [2:0] {
      RX_OFF,
      RX_STANDBY,
      RX_START,
      RX_DATA,
      RX_PARITY,
      RX_STOP
   } srei_rx_state_t;

endpackage : srei_pkg

// ===== srei_remote.sv
// Model of the remote serial transmitter and synchronous master
`timescale 1ns/1ns
module srei_remote (
   input wire logic clk_i,
   input wire logic sclk_m_i,
   output logic sin_o,
   output logic sclk_o
);
   logic [7:0] msh;

   // ---------------------------------------------
   // Idle levels: data line pulled up, clock high
   // ---------------------------------------------
   initial begin
      sin_o = 1'b1;
      sclk_o = 1'b1;
      msh = 8'h00;
   end

   // Async frame, LSB first, 32 clocks per bit (16 ticks of 2 clocks)
   task automatic send_async(input logic [11:0] b, input int n);
      for (int i = 0; i < n; i++) begin
         sin_o <= b[i];
         repeat (32) @(posedge clk_i);
      end
      sin_o <= 1'b1; // Pull-up takes the line after the frame
   endtask : send_async

   // Slave clocking: 800 ns period, eight system clocks per bit
   task automatic send_sync(input logic [7:0] d);
      @(posedge clk_i);
      for (int i = 0; i < 8; i++) begin
         sclk_o <= 1'b0;
         sin_o <= d[i];
         repeat (4) @(posedge clk_i);
         sclk_o <= 1'b1;
         repeat (4) @(posedge clk_i);
      end
      sin_o <= ~d[7]; // Hold time over: the last bit must not linger
   endtask : send_sync

   task automatic load_master(input logic [7:0] d);
      msh = d;
   endtask : load_master

   // Master mode: next bit goes out on each falling clock from the block
   always @(negedge sclk_m_i) begin
      sin_o <= msh[0];
      msh <= {1'b0, msh[7:1]};
   end
endmodule : srei_remote

// ===== tb_top.sv
// Self-checking testbench of the serial receive, error and interrupt block
`timescale 1ns/1ns
module tb_top;
   logic clk_i, rst_n_i, psel, penable, pwrite, tick, tx_done, lvl_lo, lvl_hi;
   logic pready, pslverr, sin, sclk, sclk_m, sclk_oe, slave_ready_out, ierr, irx, itx;
   logic err;
   logic [17:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [23:0] vec;
   int bad_count, checked, cyc;

   srei_rx_ctrl #(.ADDR_W(18)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .ce_i(1'b1), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .timer_tick_i(tick),
      .sin_i(sin), .sclk_i(sclk), .tx_done_i(tx_done),
      .cpu_irq_level_low_i(lvl_lo), .cpu_irq_level_high_i(lvl_hi),
      .sclk_o(sclk_m), .sclk_oe_o(sclk_oe), .slave_ready_out_o(slave_ready_out),
      .irq_err_req_o(ierr), .irq_rx_req_o(irx), .irq_tx_req_o(itx),
      .irq_vec_o(vec));
   srei_remote far (.clk_i(clk_i), .sclk_m_i(sclk_m), .sin_o(sin),
      .sclk_o(sclk));

   // ---------------------------------------------
   // Clock, timer ticks and hang guard
   // ---------------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      tick <= ~tick;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         end_sim();
      end
   end

   task automatic chk(input string nm, input logic [31:0] s, e);
      checked++;
      if (s !== e) begin
         bad_count++;
         $display("unexpected %s: expected %h seen %h", nm, e, s);
      end
   endtask : chk

   // APB transfer; pready, pslverr and read data taken at the ending edge
   task automatic apb(input logic w, input logic [15:0] idx,
                      input logic [7:0] d);
      @(posedge clk_i);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h000000, d};
      @(posedge clk_i);
      penable <= 1'b1;
      @(posedge clk_i);
      while (pready !== 1'b1) @(posedge clk_i);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [15:0] idx, input logic [7:0] d);
      apb(1'b1, idx, d);
   endtask : wr

   task automatic rdchk(input string nm, input logic [15:0] idx,
                        input logic [7:0] e);
      apb(1'b0, idx, 8'h00);
      chk(nm, rd, {24'h000000, e});
   endtask : rdchk

   // Frame of start, eight data bits, parity and one stop bit
   function automatic logic [11:0] frm(input logic [7:0] d, input logic p,
                                       input logic s);
      return {1'b0, s, p, d, 1'b0};
   endfunction : frm

   task automatic end_sim();
      if (bad_count == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_sim

   // Registers, unmapped access, good frame with busy readback
   task automatic t_good();
      wr(srei_pkg::IDX_PRIO, 8'h30);
      rdchk("prio", srei_pkg::IDX_PRIO, 8'h30);
      wr(srei_pkg::IDX_ENA, 8'h07);
      rdchk("ena", srei_pkg::IDX_ENA, 8'h07);
      rdchk("unmapped", 16'hFF40, 8'h00);
      chk("slverr", err, 1);
      wr(srei_pkg::IDX_CTRL, 8'h53);
      fork
         far.send_async(frm(8'hA5, ^8'hA5, 1'b1), 11);
         begin
            repeat (150) @(posedge clk_i);
            rdchk("busy", srei_pkg::IDX_CTRL, 8'h53);
         end
      join
      repeat (4) @(posedge clk_i);
      rdchk("idle", srei_pkg::IDX_CTRL, 8'h51);
      rdchk("data", srei_pkg::IDX_DATA, 8'hA5);
      rdchk("fac", srei_pkg::IDX_FAC, 8'h02);
      rdchk("stat", srei_pkg::IDX_STAT, 8'h00);
      chk("vec", vec, srei_pkg::VEC_RX);
      chk("irq_rx", irx, 1);
      wr(srei_pkg::IDX_FAC, 8'h02);
      rdchk("fac_clr", srei_pkg::IDX_FAC, 8'h00);
   endtask : t_good

   // Odd parity mismatch plus low stop bit, then overrun without trigger
   task automatic t_errors();
      wr(srei_pkg::IDX_CTRL, 8'h00); // Enable off before parity change
      wr(srei_pkg::IDX_CTRL, 8'h71);
      wr(srei_pkg::IDX_CTRL, 8'h73); // Trigger marks the buffer empty
      far.send_async(frm(8'h3C, ^8'h3C, 1'b0), 11);
      repeat (4) @(posedge clk_i);
      rdchk("stat_pf", srei_pkg::IDX_STAT, 8'h03);
      rdchk("fac_pf", srei_pkg::IDX_FAC, 8'h03);
      rdchk("data_pf", srei_pkg::IDX_DATA, 8'h3C);
      chk("vec_err", vec, srei_pkg::VEC_ERR);
      chk("irq_err", ierr, 1);
      chk("irq_rx_masked", irx, 0);
      wr(srei_pkg::IDX_STAT, 8'h07);
      wr(srei_pkg::IDX_FAC, 8'h07); // Handler clears both factors
      far.send_async(frm(8'h81, ~^8'h81, 1'b1), 11); // Good odd parity
      repeat (4) @(posedge clk_i);
      rdchk("stat_ovr", srei_pkg::IDX_STAT, 8'h04);
      rdchk("fac_ovr", srei_pkg::IDX_FAC, 8'h01);
      rdchk("data_ovr", srei_pkg::IDX_DATA, 8'h81);
      wr(srei_pkg::IDX_STAT, 8'h00);
      rdchk("stat_w0", srei_pkg::IDX_STAT, 8'h04);
      wr(srei_pkg::IDX_STAT, 8'h04);
      wr(srei_pkg::IDX_FAC, 8'h01);
      rdchk("stat_w1", srei_pkg::IDX_STAT, 8'h00);
   endtask : t_errors

   // Transmit-done flag with enable and priority gating
   task automatic t_tx();
      wr(srei_pkg::IDX_ENA, 8'h03);
      @(posedge clk_i);
      tx_done <= 1'b1;
      @(posedge clk_i);
      tx_done <= 1'b0;
      repeat (3) @(posedge clk_i);
      chk("irq_tx_off", itx, 0);
      rdchk("fac_tx", srei_pkg::IDX_FAC, 8'h04);
      wr(srei_pkg::IDX_ENA, 8'h07);
      repeat (3) @(posedge clk_i);
      chk("irq_tx", itx, 1);
      chk("vec_tx", vec, srei_pkg::VEC_TX);
      lvl_lo <= 1'b1;
      lvl_hi <= 1'b1;
      repeat (3) @(posedge clk_i);
      chk("irq_tx_lvl", itx, 0);
      lvl_lo <= 1'b0;
      lvl_hi <= 1'b0;
      wr(srei_pkg::IDX_FAC, 8'h04);
   endtask : t_tx

   // Synchronous slave: ready output, word, and overrun when unread
   task automatic t_slave();
      wr(srei_pkg::IDX_CTRL, 8'h00); // Enable off before mode change
      wr(srei_pkg::IDX_CTRL, 8'h09);
      for (int k = 0; k < 2; k++) begin
         wr(srei_pkg::IDX_CTRL, 8'h0B);
         @(negedge clk_i);
         chk("ready_low", slave_ready_out, 0);
         far.send_sync(8'h96 ^ k[7:0]);
         repeat (6) @(posedge clk_i);
         chk("ready_high", slave_ready_out, 1);
      end
      rdchk("stat_slv", srei_pkg::IDX_STAT, 8'h04);
      rdchk("data_slv", srei_pkg::IDX_DATA, 8'h97);
      wr(srei_pkg::IDX_STAT, 8'h04);
      wr(srei_pkg::IDX_FAC, 8'h07);
   endtask : t_slave

   // Synchronous master: clock pin enabled, one triggered word
   task automatic t_master();
      wr(srei_pkg::IDX_CTRL, 8'h00);
      wr(srei_pkg::IDX_CTRL, 8'h05);
      @(negedge clk_i);
      chk("sclk_oe", sclk_oe, 1);
      far.load_master(8'hC3);
      wr(srei_pkg::IDX_CTRL, 8'h07);
      do apb(1'b0, srei_pkg::IDX_CTRL, 8'h00); while (rd[1] === 1'b1);
      chk("sclk_idle", sclk_m, 1);
      rdchk("data_mst", srei_pkg::IDX_DATA, 8'hC3);
      rdchk("fac_mst", srei_pkg::IDX_FAC, 8'h02);
   endtask : t_master

   // ---------------------------------------------
   // Main sequence
   // ---------------------------------------------
   initial begin
      rst_n_i = 1'b0;
      {psel, penable, pwrite, tick, tx_done, lvl_lo, lvl_hi} = 7'h00;
      paddr = 18'h00000;
      pwdata = 32'h00000000;
      bad_count = 0;
      checked = 0;
      cyc = 0;
      repeat (2) @(posedge clk_i);
      rst_n_i <= 1'b1;
      t_good();
      t_errors();
      t_tx();
      t_slave();
      t_master();
      end_sim();
   end
endmodule : tb_top
